// File: common/bich_map.vh
// constants for the initialise command handler
// assumes a byte-wide boot link and a 32-bit apb slave
`ifndef BICH_MAP_VH
`define BICH_MAP_VH

// packet and reply constants: framing bytes, codes, lengths, fill word
`define BICH_SOH        8'h01
`define BICH_ETX        8'h03
`define BICH_SOD        8'h81
`define BICH_RESP_LNH   8'h00
`define BICH_RESP_LNL   8'h0A
`define BICH_CMD_INIT   8'h50
`define BICH_RES_ERR    8'hD0
`define BICH_LC_OEM     8'h04
`define BICH_CMD_LEN    16'h0003
`define BICH_PKT_LEN_MAX 16'h0400
`define BICH_FILL       32'hFFFFFFFF
`define BICH_RESP_LAST  4'hE

// status codes
`define BICH_STS_OK     8'h00
`define BICH_STS_PKT    8'hC1
`define BICH_STS_SUM    8'hC2
`define BICH_STS_ACC    8'hC3
`define BICH_STS_PARAM  8'hC5
`define BICH_STS_PROT   8'hDA
`define BICH_STS_FLASH  8'hE1
`define BICH_STS_HW     8'hE3

// initialisation steps, last one is the level change
`define BICH_STEP_FIRST 3'h0
`define BICH_STEP_LEVEL 3'h6
`define BICH_PL_TWO     2'h2

// apb map
`define BICH_A_CFG      8'h00
`define BICH_A_STAT     8'h04
`define BICH_A_DET      8'h08
`define BICH_A_ADR      8'h0C

// config register fields
`define BICH_CFG_PERMIT 0
`define BICH_CFG_INIDIS 1
`define BICH_CFG_L2DIS  2
`define BICH_CFG_STARTUP_PROTECT_FLAG   3
`define BICH_CFG_EELOCK 4
`define BICH_CFG_ARCLK  5
`define BICH_CFG_LC_LO  8
`define BICH_CFG_RST    32'h00000008

`endif

// File: verilog/bich_core.v
// initialise command handler: frame check, checks, area wipe, reply
// assumes byte strobes from the boot link, one flash sequencer,
// and software setting the config word over apb before use
// Notes on behaviour
// - idle drops all bytes except header marker
// - missing terminator gives packet error
// - bad checksum gives checksum error
// - bad length field gives packet error
// - any check error: no execution, back idle
// - checks run framing, acceptance, parameters, protection
// - lifecycle forbids command: acceptance error
// - encrypted write without reset: acceptance error
// - source code mismatch gives parameter error
// - destination not oem gives parameter error
// - init or level-two key disabled: protection error
// - any zero protect vector bit: protection error
// - startup protect flag zero: protection error
// - locked eeprom config area: protection error
// - rollback counter lock never blocks initialisation
// - wipe areas in order, failure gives flash error
// - flash fault reports status, address if disclosed
// - level change failure: flash error, keep serving
// - invalid level: hardware error, then silent
// - success: ok reply, then silent
// - key disable, boot lock, rollback, external untouched
// - report only highest error, fill unused fields
// - packet holds opcode, source, destination codes
// - wipe ignores block protection settings
`include "bich_map.vh"
module bich_core #(
   parameter [15:0] PKT_LEN_MAX = `BICH_PKT_LEN_MAX
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         rx_valid,
   input  wire [7:0]   rx_data,
   output wire         tx_valid,
   output wire [7:0]   tx_data,
   input  wire         tx_ready,
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [7:0]   paddr,
   input  wire [31:0]  pwdata,
   output wire [31:0]  prdata,
   output wire         pready,
   output wire         pslverr,
   input  wire         enc_write_done,
   input  wire [139:0] permanent_block_protect_vector,
   input  wire [139:0] permanent_block_protect_secure_vector,
   output wire         fci_req,
   output wire [2:0]   fci_step,
   output wire         fci_ignore_bps,
   input  wire         fci_done,
   input  wire         fci_err,
   input  wire [31:0]  fci_fstat,
   input  wire [31:0]  fci_addr,
   input  wire         fci_disclosed,
   input  wire [1:0]   prot_level,
   output wire         halted
);

   localparam S_IDLE = 4'h0;
   localparam S_LNH  = 4'h1;
   localparam S_LNL  = 4'h2;
   localparam S_DATA = 4'h3;
   localparam S_SUM  = 4'h4;
   localparam S_ETX  = 4'h5;
   localparam S_CHK  = 4'h6;
   localparam S_EXEC = 4'h7;
   localparam S_SEND = 4'h8;
   localparam S_HALT = 4'h9;
   reg [3:0]   state_q;
   reg [15:0]  len_q;
   reg [15:0]  cnt_q;
   reg [7:0]   sum_q;
   reg [7:0]   cmd_q;
   reg [7:0]   src_q;
   reg [7:0]   dst_q;
   reg         etx_ok_q;
   reg         enc_seen_q;
   reg [2:0]   step_q;
   reg         req_q;
   reg         stop_q;
   reg [7:0]   res_q;
   reg [7:0]   sts_q;
   reg [31:0]  st2_q;
   reg [31:0]  adr_q;
   reg [3:0]   idx_q;
   reg [7:0]   txd_q;
   reg [31:0]  cfg_q;
   reg [31:0]  rd_q;
   wire [15:0] len_full = {len_q[15:8], rx_data};
   wire [7:0]  lc_state = cfg_q[`BICH_CFG_LC_LO +: 8];

   ////////////////////////////////////////////////////////////////////
   // check chain, first failing check wins
   reg         chk_err;
   reg [7:0]   chk_sts;
   always @* begin
      chk_err = 1'b1;
      chk_sts = `BICH_STS_OK;
      if (!etx_ok_q) begin
         chk_sts = `BICH_STS_PKT;
      end else if (sum_q != 8'h00) begin
         chk_sts = `BICH_STS_SUM;
      end else if (len_q == 16'h0000 || len_q > PKT_LEN_MAX ||
                   len_q != `BICH_CMD_LEN) begin
         chk_sts = `BICH_STS_PKT;
      end else if (cmd_q != `BICH_CMD_INIT) begin
         chk_sts = `BICH_STS_ACC;
      end else if (!cfg_q[`BICH_CFG_PERMIT]) begin
         chk_sts = `BICH_STS_ACC;
      end else if (enc_seen_q) begin
         chk_sts = `BICH_STS_ACC;
      end else if (src_q != lc_state) begin
         chk_sts = `BICH_STS_PARAM;
      end else if (dst_q != `BICH_LC_OEM) begin
         chk_sts = `BICH_STS_PARAM;
      end else if (cfg_q[`BICH_CFG_INIDIS] | cfg_q[`BICH_CFG_L2DIS]) begin
         chk_sts = `BICH_STS_PROT;
      end else if (!(&permanent_block_protect_vector) |
                   !(&permanent_block_protect_secure_vector)) begin
         chk_sts = `BICH_STS_PROT;
      end else if (!cfg_q[`BICH_CFG_STARTUP_PROTECT_FLAG]) begin
         chk_sts = `BICH_STS_PROT;
      end else if (cfg_q[`BICH_CFG_EELOCK]) begin
         chk_sts = `BICH_STS_PROT;
      end else begin
         chk_err = 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // reply byte selection and checksum
   wire [7:0] rsum_pos = `BICH_RESP_LNH + `BICH_RESP_LNL + res_q + sts_q
                       + st2_q[31:24] + st2_q[23:16] + st2_q[15:8] + st2_q[7:0]
                       + adr_q[31:24] + adr_q[23:16] + adr_q[15:8] + adr_q[7:0];
   wire [7:0] rsum = 8'h00 - rsum_pos;
   function [7:0] resp_byte;
      input [3:0] i;
      begin
         case (i)
            4'h0:    resp_byte = `BICH_SOD;
            4'h1:    resp_byte = `BICH_RESP_LNH;
            4'h2:    resp_byte = `BICH_RESP_LNL;
            4'h3:    resp_byte = res_q;
            4'h4:    resp_byte = sts_q;
            4'h5:    resp_byte = st2_q[31:24];
            4'h6:    resp_byte = st2_q[23:16];
            4'h7:    resp_byte = st2_q[15:8];
            4'h8:    resp_byte = st2_q[7:0];
            4'h9:    resp_byte = adr_q[31:24];
            4'hA:    resp_byte = adr_q[23:16];
            4'hB:    resp_byte = adr_q[15:8];
            4'hC:    resp_byte = adr_q[7:0];
            4'hD:    resp_byte = rsum;
            4'hE:    resp_byte = `BICH_ETX;
            default: resp_byte = 8'h00;
         endcase
      end
   endfunction
   ////////////////////////////////////////////////////////////////////
   // sticky encrypted-write flag, cleared only by device reset
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         enc_seen_q <= 1'b0;
      end else if (enc_write_done) begin
         enc_seen_q <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // main sequencer
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q  <= S_IDLE;
         len_q    <= 16'h0000;
         cnt_q    <= 16'h0000;
         sum_q    <= 8'h00;
         cmd_q    <= 8'h00;
         src_q    <= 8'h00;
         dst_q    <= 8'h00;
         etx_ok_q <= 1'b0;
         step_q   <= `BICH_STEP_FIRST;
         req_q    <= 1'b0;
         stop_q   <= 1'b0;
         res_q    <= `BICH_RES_ERR;
         sts_q    <= `BICH_STS_OK;
         st2_q    <= `BICH_FILL;
         adr_q    <= `BICH_FILL;
         idx_q    <= 4'h0;
         txd_q    <= 8'h00;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (rx_valid && rx_data == `BICH_SOH) begin
                  sum_q   <= 8'h00;
                  cnt_q   <= 16'h0000;
                  state_q <= S_LNH;
               end
            end
            S_LNH: begin
               if (rx_valid) begin
                  len_q[15:8] <= rx_data;
                  sum_q       <= sum_q + rx_data;
                  state_q     <= S_LNL;
               end
            end
            S_LNL: begin
               if (rx_valid) begin
                  len_q[7:0] <= rx_data;
                  sum_q      <= sum_q + rx_data;
                  state_q    <= (len_full == 16'h0000) ? S_SUM : S_DATA;
               end
            end
            S_DATA: begin
               if (rx_valid) begin
                  sum_q <= sum_q + rx_data;
                  cnt_q <= cnt_q + 16'h0001;
                  if (cnt_q == 16'h0000)
                     cmd_q <= rx_data;
                  if (cnt_q == 16'h0001)
                     src_q <= rx_data;
                  if (cnt_q == 16'h0002)
                     dst_q <= rx_data;
                  if (cnt_q + 16'h0001 == len_q)
                     state_q <= S_SUM;
               end
            end
            S_SUM: begin
               if (rx_valid) begin
                  sum_q   <= sum_q + rx_data;
                  state_q <= S_ETX;
               end
            end
            S_ETX: begin
               if (rx_valid) begin
                  etx_ok_q <= (rx_data == `BICH_ETX);
                  state_q  <= S_CHK;
               end
            end
            S_CHK: begin
               st2_q <= `BICH_FILL;
               adr_q <= `BICH_FILL;
               if (chk_err) begin
                  res_q   <= `BICH_RES_ERR;
                  sts_q   <= chk_sts;
                  stop_q  <= 1'b0;
                  idx_q   <= 4'h0;
                  txd_q   <= `BICH_SOD;
                  state_q <= S_SEND;
               end else begin
                  step_q  <= `BICH_STEP_FIRST;
                  req_q   <= 1'b1;
                  state_q <= S_EXEC;
               end
            end
            // one area at a time, in order
            S_EXEC: begin
               if (fci_done) begin
                  idx_q <= 4'h0;
                  txd_q <= `BICH_SOD;
                  if (fci_err) begin
                     req_q   <= 1'b0;
                     res_q   <= `BICH_RES_ERR;
                     sts_q   <= `BICH_STS_FLASH;
                     st2_q   <= fci_fstat;
                     adr_q   <= fci_disclosed ? fci_addr : `BICH_FILL;
                     stop_q  <= 1'b0;
                     state_q <= S_SEND;
                  end else if (step_q == `BICH_STEP_LEVEL) begin
                     req_q   <= 1'b0;
                     stop_q  <= 1'b1;
                     state_q <= S_SEND;
                     if (prot_level == `BICH_PL_TWO) begin
                        res_q <= `BICH_CMD_INIT;
                        sts_q <= `BICH_STS_OK;
                     end else begin
                        res_q <= `BICH_RES_ERR;
                        sts_q <= `BICH_STS_HW;
                     end
                  end else begin
                     step_q <= step_q + 3'h1;
                  end
               end
            end
            S_SEND: begin
               if (tx_ready) begin
                  if (idx_q == `BICH_RESP_LAST) begin
                     // silent after ok or hardware error
                     state_q <= stop_q ? S_HALT : S_IDLE;
                  end else begin
                     idx_q <= idx_q + 4'h1;
                     txd_q <= resp_byte(idx_q + 4'h1);
                  end
               end
            end
            S_HALT:  state_q <= S_HALT;
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   assign tx_valid = (state_q == S_SEND);
   assign tx_data  = txd_q;
   assign halted   = (state_q == S_HALT);
   assign fci_req        = req_q;
   assign fci_step       = step_q;
   assign fci_ignore_bps = req_q;

   ////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   wire acc   = psel & penable;
   wire setup = psel & ~penable;
   wire hit   = (paddr == `BICH_A_CFG) | (paddr == `BICH_A_STAT) |
                (paddr == `BICH_A_DET) | (paddr == `BICH_A_ADR);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q <= `BICH_CFG_RST;
         rd_q  <= 32'h00000000;
      end else begin
         if (acc && pwrite && paddr == `BICH_A_CFG)
            cfg_q <= pwdata;
         if (setup) begin
            case (paddr)
               `BICH_A_CFG:  rd_q <= cfg_q;
               `BICH_A_STAT: rd_q <= {14'h0000, halted, enc_seen_q, 4'h0, state_q, sts_q};
               `BICH_A_DET:  rd_q <= st2_q;
               `BICH_A_ADR:  rd_q <= adr_q;
               default:      rd_q <= 32'h00000000;
            endcase
         end
      end
   end
   assign prdata  = rd_q;
   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;
endmodule // bich_core

// File: dv/bich_core_assertions.sv
// checker bound onto the initialise command handler
// assumes one clock domain and rst active high
`include "bich_map.vh"
module bich_chk (
   input logic       clk,
   input logic       rst,
   input logic       tx_valid,
   input logic [7:0] tx_data,
   input logic       tx_ready,
   input logic       fci_req,
   input logic [2:0] fci_step,
   input logic       fci_ignore_bps,
   input logic       fci_done,
   input logic       fci_err,
   input logic       halted
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_quiet;
      halted |-> !tx_valid && !fci_req;
   endproperty
   a_quiet: assert property (p_quiet) else $error("busy while halted");
   property p_keep;
      halted |=> halted;
   endproperty
   a_keep: assert property (p_keep) else $error("halt lost");
   property p_sod;
      $rose(tx_valid) |-> tx_data == `BICH_SOD;
   endproperty
   a_sod: assert property (p_sod) else $error("bad reply start");
   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_hold: assert property (p_hold) else $error("reply byte lost");
   property p_first;
      $rose(fci_req) |-> fci_step == `BICH_STEP_FIRST;
   endproperty
   a_first: assert property (p_first) else $error("wipe starts late");
   property p_next;
      fci_req && fci_done && !fci_err && fci_step != `BICH_STEP_LEVEL
         |=> fci_req && fci_step == $past(fci_step) + 3'h1;
   endproperty
   a_next: assert property (p_next) else $error("wipe order");
   property p_fail;
      fci_req && fci_done && fci_err |=> !fci_req ##[0:4] tx_valid;
   endproperty
   a_fail: assert property (p_fail) else $error("wipe fault kept going");
   property p_bps;
      fci_ignore_bps == fci_req;
   endproperty
   a_bps: assert property (p_bps) else $error("protection honoured");
   c_lvl: cover property (fci_done && fci_step == `BICH_STEP_LEVEL);
   c_err: cover property (fci_done && fci_err);
   c_halt: cover property ($rose(halted));
endmodule // bich_chk

bind bich_core bich_chk chk_u (.clk, .rst, .tx_valid, .tx_data, .tx_ready, .fci_req,
   .fci_step, .fci_ignore_bps, .fci_done, .fci_err, .halted);

// File: dv/bich_host.sv
// host tool model on the boot link
// assumes send is called just after a rising edge
`include "bich_map.vh"
module bich_host (
   input  logic       clk,
   output logic       rx_valid,
   output logic [7:0] rx_data,
   output logic       tx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
   end
   // stalls the reply now and then
   always @(posedge clk) begin
      tx_ready <= ($urandom % 4) != 0;
   end
   task automatic send(input logic [7:0] src, dst, length_low, sx, etx, input logic junk);
      logic [7:0] pk [0:15];
      logic [7:0] s;
      int         n;
      n = 0;
      if (junk) begin
         pk[0] = 8'h5A;
         n = 1;
      end
      pk[n] = `BICH_SOH;
      pk[n + 1] = 8'h00;
      pk[n + 2] = length_low;
      n += 3;
      s = length_low;
      for (int i = 0; i < length_low; i++) begin
         pk[n] = (i == 0) ? `BICH_CMD_INIT : (i == 1) ? src : (i == 2) ? dst : 8'h00;
         s = s + pk[n];
         n++;
      end
      pk[n] = (8'h00 - s) ^ sx;
      pk[n + 1] = etx;
      n += 2;
      for (int i = 0; i < n; i++) begin
         rx_valid <= 1'b1;
         rx_data  <= pk[i];
         @(posedge clk);
      end
      rx_valid <= 1'b0;
      rx_data  <= ~pk[n - 1];
   endtask
endmodule // bich_host

// File: dv/tb.sv
// self-checking bench for the initialise command handler
// assumes bich_core, the host model and the checker compiled first
`include "bich_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk, rst, rx_valid, tx_valid, tx_ready, psel, penable, pwrite;
   logic         pready, pslverr, enc_write_done, fci_req, fci_ignore_bps;
   logic         fci_done, fci_err, fci_disclosed, halted;
   logic [7:0]   rx_data, tx_data, paddr;
   logic [31:0]  pwdata, prdata, fci_fstat, fci_addr;
   logic [139:0] pbv, psv;
   logic [2:0]   fci_step, fail_step;
   logic [1:0]   prot_level;
   logic [7:0]   exp_q [$];
   int           n_errors, cmp_count, step_n;

   bich_core dut_u (.clk, .rst, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .enc_write_done, .permanent_block_protect_vector(pbv),
      .permanent_block_protect_secure_vector(psv), .fci_req, .fci_step,
      .fci_ignore_bps, .fci_done, .fci_err, .fci_fstat, .fci_addr, .fci_disclosed,
      .prot_level, .halted);
   bich_host host_u (.clk, .rx_valid, .rx_data, .tx_ready);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         if (exp_q.size() == 0)
            check("unexpected byte", {24'h0, tx_data}, 32'hFFFFFFFF);
         else
            check("reply byte", {24'h0, tx_data}, {24'h0, exp_q.pop_front()});
      end
   end

   // flash sequencer: random latency, fault on a chosen step
   always @(posedge clk) begin : flash_model
      logic go;
      go = fci_req && !fci_done && ($urandom % 2);
      fci_done <= go;
      fci_err  <= go && fci_step == fail_step;
      if (fci_req && fci_done) begin
         check("wipe step", {29'h0, fci_step}, step_n);
         step_n++;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rst_cycle();
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   // host waits for the whole reply
   task automatic run(input logic [7:0] src, dst, length_low, sx, etx, sts,
                      input logic [31:0] st2, adr);
      logic [7:0] r [0:14];
      logic [7:0] s;
      r = '{`BICH_SOD, `BICH_RESP_LNH, `BICH_RESP_LNL,
            (sts == `BICH_STS_OK) ? `BICH_CMD_INIT : `BICH_RES_ERR, sts,
            st2[31:24], st2[23:16], st2[15:8], st2[7:0],
            adr[31:24], adr[23:16], adr[15:8], adr[7:0], 8'h00, `BICH_ETX};
      s = 8'h00;
      for (int i = 1; i < 13; i++)
         s = s + r[i];
      r[13] = 8'h00 - s;
      step_n = 0;
      foreach (r[i])
         exp_q.push_back(r[i]);
      host_u.send(src, dst, length_low, sx, etx, 1'b1);
      wait (exp_q.size() == 0);
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] rd, fs, fa, base;
      logic [31:0] prot [0:5];
      logic        er;
      logic [7:0]  rv;
      {psel, penable, pwrite, enc_write_done, fci_disclosed} = '0;
      {paddr, pwdata, fci_fstat, fci_addr} = '0;
      pbv = '1;
      psv = '1;
      prot_level = `BICH_PL_TWO;
      fail_step = 3'h7;
      rst = 1'b1;
      void'($urandom(46559));
      rst_cycle();
      apb(1'b0, `BICH_A_CFG, 32'h0, rd, er);
      check("cfg reset", rd, `BICH_CFG_RST);
      apb(1'b0, 8'h40, 32'h0, rd, er);
      check("unmapped error", {31'h0, er}, 32'h1);
      base = 32'h00000409;
      apb(1'b1, `BICH_A_CFG, base, rd, er);
      apb(1'b0, `BICH_A_CFG, 32'h0, rd, er);
      check("cfg readback", rd, base);
      run(8'h04, 8'h04, 8'h03, 8'h00, 8'h00, `BICH_STS_PKT, `BICH_FILL, `BICH_FILL);
      run(8'h04, 8'h04, 8'h03, 8'h01, 8'h03, `BICH_STS_SUM, `BICH_FILL, `BICH_FILL);
      run(8'h04, 8'h04, 8'h04, 8'h00, 8'h03, `BICH_STS_PKT, `BICH_FILL, `BICH_FILL);
      run(8'h07, 8'h04, 8'h03, 8'h01, 8'h03, `BICH_STS_SUM, `BICH_FILL, `BICH_FILL);
      apb(1'b1, `BICH_A_CFG, base & ~32'h1, rd, er);
      run(8'h07, 8'h04, 8'h03, 8'h00, 8'h03, `BICH_STS_ACC, `BICH_FILL, `BICH_FILL);
      rv = $urandom;
      rv[7] = 1'b1;
      prot = '{base | 32'h2, base | 32'h4, base & ~32'h8, base | 32'h10, base, base | 32'h6};
      foreach (prot[i]) begin
         apb(1'b1, `BICH_A_CFG, prot[i], rd, er);
         if (i == 4)
            pbv[$urandom % 140] <= 1'b0;
         if (i == 5)
            psv[$urandom % 140] <= 1'b0;
         run(8'h04, 8'h04, 8'h03, 8'h00, 8'h03, `BICH_STS_PROT, `BICH_FILL, `BICH_FILL);
      end
      run(rv, 8'h04, 8'h03, 8'h00, 8'h03, `BICH_STS_PARAM, `BICH_FILL, `BICH_FILL);
      run(8'h04, rv, 8'h03, 8'h00, 8'h03, `BICH_STS_PARAM, `BICH_FILL, `BICH_FILL);
      check("no wipe on error", step_n, 0);
      pbv <= '1;
      psv <= '1;
      apb(1'b1, `BICH_A_CFG, base, rd, er);
      for (int s = 0; s < 7; s++) begin
         fail_step = s[2:0];
         fs = $urandom;
         fa = $urandom;
         fci_fstat <= fs;
         fci_addr <= fa;
         fci_disclosed <= s[0];
         run(8'h04, 8'h04, 8'h03, 8'h00, 8'h03, `BICH_STS_FLASH, fs, s[0] ? fa : `BICH_FILL);
         check("steps run", step_n, s + 1);
         apb(1'b0, `BICH_A_DET, 32'h0, rd, er);
         check("detail reg", rd, fs);
      end
      fail_step = 3'h7;
      prot_level <= 2'h3;
      run(8'h04, 8'h04, 8'h03, 8'h00, 8'h03, `BICH_STS_HW, `BICH_FILL, `BICH_FILL);
      host_u.send(8'h04, 8'h04, 8'h03, 8'h00, 8'h03, 1'b0);
      repeat (60) @(posedge clk);
      check("halted", {31'h0, halted}, 32'h1);
      rst_cycle();
      prot_level <= `BICH_PL_TWO;
      apb(1'b1, `BICH_A_CFG, base, rd, er);
      enc_write_done <= 1'b1;
      @(posedge clk);
      enc_write_done <= 1'b0;
      run(8'h04, 8'h04, 8'h03, 8'h00, 8'h03, `BICH_STS_ACC, `BICH_FILL, `BICH_FILL);
      rst_cycle();
      apb(1'b1, `BICH_A_CFG, base | 32'h20, rd, er);
      run(8'h04, 8'h04, 8'h03, 8'h00, 8'h03, `BICH_STS_OK, `BICH_FILL, `BICH_FILL);
      apb(1'b0, `BICH_A_STAT, 32'h0, rd, er);
      check("stat halted", {31'h0, rd[17]}, 32'h1);
      apb(1'b0, `BICH_A_CFG, 32'h0, rd, er);
      check("rollback lock kept", rd, base | 32'h20);
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      stop_test();
   end
endmodule // tb
